// File: common/lmx_pkg.sv
package lmx_pkg;
  // Instruction word layout
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int NUM_FILES = 128;
  localparam int PHASES = 4;

  // Opcode fields, bits 13:8, 13:10 or 13:7 depending on opcode
  localparam logic [5:0] OP_OR_WORK_WITH_FILE = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE_TO_DEST = 6'h08;
  localparam logic [3:0] OP_LOAD_LITERAL_HI = 4'hc;
  localparam logic [6:0] OP_STORE_WORK_HI = 7'h01;

  // Reset values
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  typedef enum logic [2:0] {
    LMX_OP_NONE = 3'b000,
    LMX_OP_OR = 3'b001,
    LMX_OP_LIT = 3'b010,
    LMX_OP_MOVE_FILE_TO_DEST = 3'b011,
    LMX_OP_STORE = 3'b100,
    LMX_OP_NOP = 3'b101
  } lmx_op_t;

  typedef enum logic [1:0] {
    LMX_Q1 = 2'b00,
    LMX_Q2 = 2'b01,
    LMX_Q3 = 2'b10,
    LMX_Q4 = 2'b11
  } lmx_phase_t;

  typedef struct packed {
    lmx_op_t op;
    logic [6:0] fileAddr;
    logic dest;
    logic [7:0] literal;
  } lmx_decoded_t;

  typedef struct packed {
    logic [7:0] work;
    logic zero;
  } lmx_core_state_t;
endpackage : lmx_pkg

// File: design/lmx_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module lmx_decoder
  import lmx_pkg::*;
(
  // Instruction word
  input wire logic [INSTR_W-1:0] instr,
  // Decoded fields
  output lmx_decoded_t decoded
);
  always_comb begin
    decoded.fileAddr = instr[FADDR_W-1:0];
    decoded.dest = instr[DEST_BIT];
    decoded.literal = instr[DATA_W-1:0];
    if (instr[13:8] == OP_OR_WORK_WITH_FILE) begin
      decoded.op = LMX_OP_OR;
    end else if (instr[13:8] == OP_MOVE_FILE_TO_DEST) begin
      decoded.op = LMX_OP_MOVE_FILE_TO_DEST;
    end else if (instr[13:10] == OP_LOAD_LITERAL_HI) begin
      decoded.op = LMX_OP_LIT;
    end else if (instr[13:7] == OP_STORE_WORK_HI) begin
      decoded.op = LMX_OP_STORE;
    end else if (instr[13:7] == 7'h00 && instr[4:0] == 5'h00) begin
      // Bits 6:5 ignored so every variant decodes alike
      decoded.op = LMX_OP_NOP;
    end else begin
      decoded.op = LMX_OP_NONE;
    end
  end
endmodule : lmx_decoder
`default_nettype wire

// File: design/lmx_exec.sv
`timescale 1ns/1ns
`default_nettype none
module lmx_exec
  import lmx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Program memory
  input wire logic [INSTR_W-1:0] instrWord,
  output logic instrFetch,
  // Observed state
  output logic [DATA_W-1:0] workReg,
  output logic zeroFlag,
  output logic [1:0] phase,
  output logic instrDone,
  output logic unknownInstr
);
  typedef struct packed {
    lmx_phase_t phase;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    lmx_core_state_t core;
    logic done;
    logic unknown;
    logic wrEn;
    logic [FADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
  } lmx_state_t;

  lmx_state_t st;
  lmx_state_t next_st;
  logic [DATA_W-1:0] files [NUM_FILES];
  lmx_decoded_t dec;
  logic rstnSafe;
  // Kept outside the state struct: it resets on the raw pin, the rest on the safe copy
  logic [1:0] rstSync;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnSafe = rstSync[1];

  lmx_decoder u_dec (
    .instr(st.instr),
    .decoded(dec)
  );

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.wrEn = 1'b0;
    case (st.phase)
      LMX_Q1: begin
        // Latch word; decode follows from the latched copy
        next_st.instr = instrWord;
        next_st.unknown = 1'b0;
        next_st.phase = LMX_Q2;
      end
      LMX_Q2: begin
        next_st.operand = (dec.op == LMX_OP_LIT) ? dec.literal : files[dec.fileAddr];
        next_st.unknown = (dec.op == LMX_OP_NONE);
        next_st.phase = LMX_Q3;
      end
      LMX_Q3: begin
        case (dec.op)
          LMX_OP_OR: next_st.result = st.core.work | st.operand;
          LMX_OP_MOVE_FILE_TO_DEST: next_st.result = st.operand;
          LMX_OP_LIT: next_st.result = st.operand;
          LMX_OP_STORE: next_st.result = st.core.work;
          default: next_st.result = st.result;
        endcase
        next_st.phase = LMX_Q4;
      end
      LMX_Q4: begin
        case (dec.op)
          LMX_OP_OR, LMX_OP_MOVE_FILE_TO_DEST: begin
            next_st.core.zero = (st.result == 8'h00);
            if (dec.dest) begin
              next_st.wrEn = 1'b1;
              next_st.wrAddr = dec.fileAddr;
              next_st.wrData = st.result;
            end else begin
              next_st.core.work = st.result;
            end
          end
          LMX_OP_LIT: next_st.core.work = st.result;
          LMX_OP_STORE: begin
            next_st.wrEn = 1'b1;
            next_st.wrAddr = dec.fileAddr;
            next_st.wrData = st.result;
          end
          default: begin
            // Nothing touched, cycle just elapses
          end
        endcase
        next_st.done = 1'b1;
        next_st.phase = LMX_Q1;
      end
      default: next_st.phase = LMX_Q1;
    endcase
  end

  always_ff @(posedge mclk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      st.phase <= LMX_Q1;
      st.instr <= '0;
      st.operand <= '0;
      st.result <= '0;
      st.core <= '{work: WORK_RESET, zero: 1'b0};
      st.done <= 1'b0;
      st.unknown <= 1'b0;
      st.wrEn <= 1'b0;
      st.wrAddr <= '0;
      st.wrData <= '0;
    end else begin
      st.phase <= next_st.phase;
      st.instr <= next_st.instr;
      st.operand <= next_st.operand;
      st.result <= next_st.result;
      st.core <= next_st.core;
      st.done <= next_st.done;
      st.unknown <= next_st.unknown;
      st.wrEn <= next_st.wrEn;
      st.wrAddr <= next_st.wrAddr;
      st.wrData <= next_st.wrData;
    end
  end

  // File write lands at the edge that closes Q1; Q2 read is captured one edge later, so no hazard
  always_ff @(posedge mclk or negedge rstnSafe) begin
    if (!rstnSafe) begin
      for (int i = 0; i < NUM_FILES; i++) begin
        files[i] <= FILE_RESET;
      end
    end else if (st.wrEn) begin
      files[st.wrAddr] <= st.wrData;
    end
  end

  assign instrFetch = (st.phase == LMX_Q1) && rstnSafe;
  assign workReg = st.core.work;
  assign zeroFlag = st.core.zero;
  assign phase = st.phase;
  assign instrDone = st.done;
  assign unknownInstr = st.unknown;
endmodule : lmx_exec
`default_nettype wire

// File: verification/lmx_exec_props.sv
`timescale 1ns/1ns
`default_nettype none
module lmx_exec_props
  import lmx_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [INSTR_W-1:0] instrWord,
  input wire logic instrFetch,
  input wire logic [DATA_W-1:0] workReg,
  input wire logic zeroFlag,
  input wire logic [1:0] phase,
  input wire logic instrDone,
  input wire logic unknownInstr
);
  logic [13:0] w;
  logic toW;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) w <= 14'h0;
    else if (instrFetch) w <= instrWord;
  end
  assign toW = (w[13:8] == 6'h04 || w[13:8] == 6'h08) && !w[7];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_take; instrFetch ##4 instrDone && phase == 2'h0; endsequence
  property p_cycle; instrFetch |-> s_take; endproperty
  property p_or; instrDone && w[13:8] == 6'h04 && !w[7] |-> (workReg | $past(workReg)) == workReg; endproperty
  property p_dest; instrDone && w[13:12] == 2'h0 && w[11:8] != 4'h0 && w[7] |-> $stable(workReg); endproperty
  property p_zero; instrDone && toW |-> zeroFlag == (workReg == 8'h00); endproperty
  property p_nop; instrDone && (w & 14'h3f9f) == 14'h0 |-> $stable(workReg) && $stable(zeroFlag); endproperty
  property p_nopdec; instrDone && (w & 14'h3f9f) == 14'h0 |-> !unknownInstr; endproperty
  property p_lit; instrDone && w[13:10] == 4'hc |-> workReg == w[7:0] && $stable(zeroFlag); endproperty
  property p_store; instrDone && w[13:7] == 7'h01 |-> $stable(workReg) && $stable(zeroFlag); endproperty
  a_cycle: assert property (p_cycle) else $error("done not 4 cycles after fetch");
  a_or: assert property (p_or) else $error("or lost bits of work");
  a_dest: assert property (p_dest) else $error("file destination changed work");
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  a_nop: assert property (p_nop) else $error("no-op changed state");
  a_nopdec: assert property (p_nopdec) else $error("no-op variant refused");
  a_lit: assert property (p_lit) else $error("literal load wrong");
  a_store: assert property (p_store) else $error("store changed work");
endmodule : lmx_exec_props
bind lmx_exec lmx_exec_props u_props (.mclk, .rstn, .instrWord, .instrFetch, .workReg,
  .zeroFlag, .phase, .instrDone, .unknownInstr);
`default_nettype wire

// File: verification/lmx_prog_mem.sv
`timescale 1ns/1ns
`default_nettype none
module lmx_prog_mem
  import lmx_pkg::*;
(
  // Core side
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instrFetch,
  output logic [INSTR_W-1:0] instrWord,
  // Image
  input wire logic [7:0][INSTR_W-1:0] prog
);
  logic [3:0] pc;
  // Past the image only no-op words, so the core idles
  assign instrWord = pc[3] ? 14'h0 : prog[pc[2:0]];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) pc <= 4'h0;
    else if (instrFetch && !pc[3]) pc <= pc + 4'h1;
  end
endmodule : lmx_prog_mem
`default_nettype wire

// File: verification/logic_move_nop_instruction_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module logic_move_nop_instruction_exec_tb import lmx_pkg::*;;
  logic mclk, rstn, instrFetch, zeroFlag, instrDone, unknownInstr;
  logic [INSTR_W-1:0] instrWord;
  logic [DATA_W-1:0] workReg;
  logic [1:0] phase;
  logic [7:0][INSTR_W-1:0] prog;
  int fail_count, check_count, cycles;
  lmx_exec dut (.mclk, .rstn, .instrWord, .instrFetch, .workReg, .zeroFlag, .phase,
    .instrDone, .unknownInstr);
  lmx_prog_mem pm (.mclk, .rstn, .instrFetch, .instrWord, .prog);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // Reset mid-run each time, then step through eight words
  task automatic runProg(input logic [7:0][13:0] p, input logic [7:0][7:0] eW,
                         input logic [7:0] eZ, input logic [7:0] eU);
    int n;
    @(posedge mclk);
    rstn <= 1'b0;
    prog <= p;
    repeat (10) @(posedge mclk);
    chk("reset", 8'h00, {instrFetch, zeroFlag, instrDone, unknownInstr, phase, 2'h0});
    chk("reset work", 8'h00, workReg);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (instrDone !== 1'b1 && n < 12);
      chk("work", eW[i], workReg);
      chk("flags", {5'h1, eZ[i], eU[i], 1'b0}, {4'h0, instrDone, zeroFlag, unknownInstr, 1'b0});
    end
  endtask : runProg
  task automatic sLoadStore;
    runProg({14'h0803, 14'h087f, 14'h30ff, 14'h0883, 14'h00ff, 14'h305a, 14'h0083, 14'h3000},
      {8'h00, 8'h5a, 8'hff, 8'h5a, 8'h5a, 8'h5a, 8'h00, 8'h00}, 8'hb0, 8'h00);
  endtask : sLoadStore
  task automatic sOrWork;
    runProg({14'h3fff, 14'h0405, 14'h3000, 14'h0805, 14'h0485, 14'h3091, 14'h0085, 14'h3313},
      {8'h93, 8'h93, 8'h00, 8'h93, 8'h91, 8'h91, 8'h13, 8'h13}, 8'h00, 8'h80);
  endtask : sOrWork
  task automatic sNop;
    runProg({14'h0008, 14'h0060, 14'h0040, 14'h0020, 14'h0000, 14'h0881, 14'h0081, 14'h3000},
      64'h0, 8'hfc, 8'h80);
  endtask : sNop
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    rstn = 1'b0;
    prog = '0;
    sLoadStore();
    sOrWork();
    sNop();
    summarize();
  end
endmodule : logic_move_nop_instruction_exec_tb
`default_nettype wire
